// File: rtl/cpu_state.sv
// cpu programmer-visible state: general registers, fetch pointer, flags
`timescale 1ns/1ns
module cpu_state
    import cpu_state_pkg::*;
(
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // vector fetch at reset
    output logic vec_rd_req,
    input wire logic vec_rd_ack,
    input wire logic [WORD_W-1:0] vec_rd_data,
    // register write port
    input wire logic reg_wr_en,
    input wire logic [BYTE_SEL_W-1:0] reg_wr_sel,
    input wire logic reg_wr_word,
    input wire logic [WORD_W-1:0] reg_wr_data,
    // register read ports
    input wire logic [BYTE_SEL_W-1:0] reg_rd_a_sel,
    input wire logic reg_rd_a_word,
    input wire logic [REG_IDX_W-1:0] addr_rd_idx,
    output logic [WORD_W-1:0] reg_rd_a_data,
    output logic [WORD_W-1:0] addr_rd_data,
    // stack pointer control
    input wire logic [1:0] stack_op,
    output logic [WORD_W-1:0] stack_top_pointer,
    // fetch pointer control
    input wire logic pc_load,
    input wire logic [WORD_W-1:0] pc_load_value,
    input wire logic pc_advance,
    output logic [WORD_W-1:0] next_fetch_pointer,
    output logic [WORD_W-1:0] fetch_addr,
    output logic fetch_ready,
    // word address alignment
    input wire logic [WORD_W-1:0] data_addr_in,
    input wire logic data_is_word,
    output logic [WORD_W-1:0] data_addr_out,
    // flag register operations
    input wire logic [2:0] flag_op,
    input wire logic [BYTE_W-1:0] flag_operand,
    input wire logic exception_start,
    output logic [BYTE_W-1:0] condition_flags,
    output logic irq_masked,
    // arithmetic flag update
    input wire logic [2:0] alu_op,
    input wire logic alu_is_word,
    input wire logic [WORD_W-1:0] alu_opa,
    input wire logic [WORD_W-1:0] alu_opb,
    input wire logic [BYTE_W-1:0] flag_upd_mask,
    output logic [WORD_W-1:0] alu_result,
    // bit accumulator and shifts
    input wire logic carry_wr_en,
    input wire logic carry_wr_value,
    output logic bit_accum,
    // branch and decimal adjust support
    input wire logic [3:0] branch_cond,
    output logic branch_taken,
    input wire logic [BYTE_W-1:0] da_in,
    input wire logic da_is_sub,
    output logic [BYTE_W-1:0] da_out
);
    // ****************************************
    // general registers
    // ****************************************
    logic [WORD_W-1:0] gpr_rd_a;
    logic [WORD_W-1:0] gpr_rd_b;
    logic [WORD_W-1:0] sp_r;
    logic [WORD_W-1:0] sp_nxt;
    logic gpr_wr_en;
    logic [REG_IDX_W-1:0] gpr_wr_idx;
    logic gpr_wr_hi;
    logic gpr_wr_lo;
    logic [WORD_W-1:0] gpr_wr_data;
    logic rd_a_word_r;
    logic rd_a_hi_r;

    // byte select: bit 3 picks low half, bits 2:0 the word register
    function automatic logic sel_is_lo(input logic [BYTE_SEL_W-1:0] sel);
        return sel[BYTE_SEL_W-1];
    endfunction

    // ****************************************
    // stack pointer shadow
    // ****************************************
    // a mirror of register seven so pushes need no extra read port
    always_comb begin
        sp_nxt = sp_r;
        if (stack_op_t'(stack_op) == STK_PUSH) begin
            sp_nxt = sp_r - STACK_STEP;
        end else if (stack_op_t'(stack_op) == STK_POP) begin
            sp_nxt = sp_r + STACK_STEP;
        end
        if (reg_wr_en && reg_wr_sel[REG_IDX_W-1:0] == STACK_REG_IDX) begin
            if (reg_wr_word || !sel_is_lo(reg_wr_sel)) begin
                sp_nxt[WORD_W-1:BYTE_W] = reg_wr_word ?
                    reg_wr_data[WORD_W-1:BYTE_W] : reg_wr_data[BYTE_W-1:0];
            end
            if (reg_wr_word || sel_is_lo(reg_wr_sel)) begin
                sp_nxt[BYTE_W-1:0] = reg_wr_data[BYTE_W-1:0];
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        sp_r <= sp_nxt;
    end

    assign stack_top_pointer = sp_r;

    always_comb begin
        gpr_wr_en = reg_wr_en || stack_op_t'(stack_op) != STK_NONE;
        gpr_wr_idx = reg_wr_sel[REG_IDX_W-1:0];
        gpr_wr_hi = reg_wr_word || !sel_is_lo(reg_wr_sel);
        gpr_wr_lo = reg_wr_word || sel_is_lo(reg_wr_sel);
        gpr_wr_data = reg_wr_word ? reg_wr_data :
            {reg_wr_data[BYTE_W-1:0], reg_wr_data[BYTE_W-1:0]};
        if (!reg_wr_en) begin
            gpr_wr_idx = STACK_REG_IDX;
            gpr_wr_hi = 1'b1;
            gpr_wr_lo = 1'b1;
            gpr_wr_data = sp_nxt;
        end
    end

    gpr_bank #(.DEPTH(NUM_WORD_REGS)) u_bank (
        .clk_sys(clk_sys),
        .wr_en(gpr_wr_en),
        .wr_idx(gpr_wr_idx),
        .wr_hi(gpr_wr_hi),
        .wr_lo(gpr_wr_lo),
        .wr_data(gpr_wr_data),
        .rd_a_idx(reg_rd_a_sel[REG_IDX_W-1:0]),
        .rd_b_idx(addr_rd_idx),
        .rd_a_data(gpr_rd_a),
        .rd_b_data(gpr_rd_b)
    );

    always_ff @(posedge clk_sys) begin
        rd_a_word_r <= reg_rd_a_word;
        rd_a_hi_r <= !sel_is_lo(reg_rd_a_sel);
    end

    always_comb begin
        if (rd_a_word_r) begin
            reg_rd_a_data = gpr_rd_a;
        end else if (rd_a_hi_r) begin
            reg_rd_a_data = {8'h00, gpr_rd_a[WORD_W-1:BYTE_W]};
        end else begin
            reg_rd_a_data = {8'h00, gpr_rd_a[BYTE_W-1:0]};
        end
    end

    assign addr_rd_data = gpr_rd_b;

    // ****************************************
    // fetch pointer
    // ****************************************
    pc_state_t state_r;
    logic [WORD_W-1:0] pc_r;

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            state_r <= ST_VECTOR;
        end else if (state_r == ST_VECTOR && vec_rd_ack) begin
            state_r <= ST_RUN;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            pc_r <= RESET_VECTOR_ADDR;
        end else if (state_r == ST_VECTOR) begin
            if (vec_rd_ack) begin
                pc_r <= vec_rd_data;
            end
        end else if (pc_load) begin
            pc_r <= pc_load_value;
        end else if (pc_advance) begin
            pc_r <= {pc_r[WORD_W-1:1], 1'b0} + STACK_STEP;
        end
    end

    assign vec_rd_req = (state_r == ST_VECTOR);
    assign fetch_ready = (state_r == ST_RUN);
    assign next_fetch_pointer = pc_r;
    assign fetch_addr = {pc_r[WORD_W-1:1], 1'b0};
    assign data_addr_out = data_is_word ?
        {data_addr_in[WORD_W-1:1], 1'b0} : data_addr_in;

    // ****************************************
    // condition flags
    // ****************************************
    logic [BYTE_W-1:0] flags_r;
    logic [BYTE_W-1:0] arith_flags;
    logic [WORD_W-1:0] calc_res;
    logic h_f;
    logic n_f;
    logic z_f;
    logic v_f;
    logic c_f;

    flag_calc u_calc (
        .alu_op(alu_op),
        .is_word(alu_is_word),
        .opa(alu_opa),
        .opb(alu_opb),
        .carry_in(flags_r[FLAG_C]),
        .result(calc_res),
        .half_out(h_f),
        .neg_out(n_f),
        .zero_out(z_f),
        .ovf_out(v_f),
        .carry_out(c_f)
    );

    assign alu_result = calc_res;

    always_comb begin
        arith_flags = flags_r;
        arith_flags[FLAG_H] = h_f;
        arith_flags[FLAG_N] = n_f;
        arith_flags[FLAG_Z] = z_f;
        arith_flags[FLAG_V] = v_f;
        arith_flags[FLAG_C] = c_f;
    end

    // priority: flag ops, then arithmetic, then carry writes; exception_start sets I over either unless a flag op runs
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            flags_r <= FLAGS_RESET;
        end else begin
            unique case (flag_op_t'(flag_op))
                FLG_LOAD: flags_r <= flag_operand;
                FLG_AND: flags_r <= flags_r & flag_operand;
                FLG_OR: flags_r <= flags_r | flag_operand;
                FLG_XOR: flags_r <= flags_r ^ flag_operand;
                default: begin
                    if (alu_op_t'(alu_op) != ALU_NONE) begin
                        // only masked-in flags move
                        flags_r <= (arith_flags & flag_upd_mask) |
                            (flags_r & ~flag_upd_mask);
                    end else if (carry_wr_en) begin
                        flags_r[FLAG_C] <= carry_wr_value;
                    end
                    if (exception_start) begin
                        flags_r[FLAG_I] <= 1'b1;
                    end
                end
            endcase
        end
    end

    assign condition_flags = flags_r;
    assign irq_masked = flags_r[FLAG_I];
    assign bit_accum = flags_r[FLAG_C];

    // ****************************************
    // branch conditions
    // ****************************************
    always_comb begin
        unique case (branch_cond[3:1])
            3'h0: branch_taken = 1'b1;
            3'h1: branch_taken = !(flags_r[FLAG_C] | flags_r[FLAG_Z]);
            3'h2: branch_taken = !flags_r[FLAG_C];
            3'h3: branch_taken = !flags_r[FLAG_Z];
            3'h4: branch_taken = !flags_r[FLAG_V];
            3'h5: branch_taken = !flags_r[FLAG_N];
            3'h6: branch_taken = !(flags_r[FLAG_N] ^ flags_r[FLAG_V]);
            3'h7: branch_taken = !(flags_r[FLAG_Z] |
                (flags_r[FLAG_N] ^ flags_r[FLAG_V]));
        endcase
        if (branch_cond[0]) begin
            branch_taken = !branch_taken;
        end
    end

    // ****************************************
    // decimal adjust
    // ****************************************
    logic [BYTE_W-1:0] da_corr;

    always_comb begin
        da_corr = 8'h00;
        if (flags_r[FLAG_H] || (!da_is_sub && da_in[3:0] > 4'h9)) begin
            da_corr[3:0] = 4'h6;
        end
        if (flags_r[FLAG_C] || (!da_is_sub && da_in > 8'h99)) begin
            da_corr[7:4] = 4'h6;
        end
        da_out = da_is_sub ? da_in - da_corr : da_in + da_corr;
    end
endmodule // cpu_state

// File: rtl/cpu_state_pkg.sv
// shared constants for the cpu register file and condition flags
package cpu_state_pkg;
    // ****************************************
    // widths and counts
    // ****************************************
    localparam int BYTE_W = 8;
    localparam int WORD_W = 16;
    localparam int NUM_WORD_REGS = 8;
    localparam int REG_IDX_W = 3;
    localparam int BYTE_SEL_W = 4;
    localparam logic [REG_IDX_W-1:0] STACK_REG_IDX = 3'h7;
    localparam logic [WORD_W-1:0] RESET_VECTOR_ADDR = 16'h0000;
    localparam logic [WORD_W-1:0] STACK_STEP = 16'h0002;
    // ****************************************
    // condition flag bit positions
    // ****************************************
    localparam int FLAG_I = 7;
    localparam int FLAG_U1 = 6;
    localparam int FLAG_H = 5;
    localparam int FLAG_U0 = 4;
    localparam int FLAG_N = 3;
    localparam int FLAG_Z = 2;
    localparam int FLAG_V = 1;
    localparam int FLAG_C = 0;
    localparam int HALF_BIT_BYTE = 4;
    localparam int HALF_BIT_WORD = 12;
    localparam logic [BYTE_W-1:0] FLAGS_RESET = 8'h80;
    // ****************************************
    // enumerations
    // ****************************************
    typedef enum logic [2:0] {
        ALU_NONE = 3'h0,
        ALU_ADD = 3'h1,
        ALU_ADDC = 3'h2,
        ALU_SUB = 3'h3,
        ALU_SUBC = 3'h4,
        ALU_CMP = 3'h5,
        ALU_NEG = 3'h6,
        ALU_LOGIC = 3'h7
    } alu_op_t;
    typedef enum logic [2:0] {
        FLG_NONE = 3'h0,
        FLG_LOAD = 3'h1,
        FLG_AND = 3'h2,
        FLG_OR = 3'h3,
        FLG_XOR = 3'h4
    } flag_op_t;
    typedef enum logic [1:0] {
        ST_VECTOR = 2'h0,
        ST_RUN = 2'h1
    } pc_state_t;
    typedef enum logic [1:0] {
        STK_NONE = 2'h0,
        STK_PUSH = 2'h1,
        STK_POP = 2'h2
    } stack_op_t;
endpackage

// File: rtl/gpr_bank.sv
// eight 16-bit general registers with byte-lane writes and two read ports
`timescale 1ns/1ns
module gpr_bank
    import cpu_state_pkg::*;
#(
    parameter int DEPTH = NUM_WORD_REGS
) (
    // clock
    input wire logic clk_sys,
    // write port
    input wire logic wr_en,
    input wire logic [REG_IDX_W-1:0] wr_idx,
    input wire logic wr_hi,
    input wire logic wr_lo,
    input wire logic [WORD_W-1:0] wr_data,
    // read ports, data registered
    input wire logic [REG_IDX_W-1:0] rd_a_idx,
    input wire logic [REG_IDX_W-1:0] rd_b_idx,
    output logic [WORD_W-1:0] rd_a_data,
    output logic [WORD_W-1:0] rd_b_data
);
    initial begin
        if (DEPTH != (1 << REG_IDX_W)) begin
            $error("gpr_bank depth must match index width");
        end
    end

    // no reset: the registers power up undefined, as software expects
    logic [WORD_W-1:0] mem_r [DEPTH];

    // ****************************************
    // write: each half only when its lane is enabled
    // ****************************************
    always_ff @(posedge clk_sys) begin
        if (wr_en && wr_hi) begin
            mem_r[wr_idx][WORD_W-1:BYTE_W] <= wr_data[WORD_W-1:BYTE_W];
        end
        if (wr_en && wr_lo) begin
            mem_r[wr_idx][BYTE_W-1:0] <= wr_data[BYTE_W-1:0];
        end
    end

    always_ff @(posedge clk_sys) begin
        rd_a_data <= mem_r[rd_a_idx];
        rd_b_data <= mem_r[rd_b_idx];
    end
endmodule // gpr_bank

// File: rtl/flag_calc.sv
// arithmetic flag computation for byte and word results
`timescale 1ns/1ns
module flag_calc
    import cpu_state_pkg::*;
(
    // operation
    input wire logic [2:0] alu_op,
    input wire logic is_word,
    input wire logic [WORD_W-1:0] opa,
    input wire logic [WORD_W-1:0] opb,
    input wire logic carry_in,
    // results
    output logic [WORD_W-1:0] result,
    output logic half_out,
    output logic neg_out,
    output logic zero_out,
    output logic ovf_out,
    output logic carry_out
);
    logic [WORD_W:0] sum;
    logic [WORD_W-1:0] a;
    logic [WORD_W-1:0] b;
    logic cin;
    logic sub;
    int msb;
    int hb;

    always_comb begin
        a = opa;
        b = opb;
        cin = 1'b0;
        sub = 1'b0;
        unique case (alu_op_t'(alu_op))
            ALU_ADD: cin = 1'b0;
            ALU_ADDC: cin = carry_in;
            ALU_SUB, ALU_CMP: sub = 1'b1;
            ALU_SUBC: begin
                sub = 1'b1;
                cin = carry_in;
            end
            ALU_NEG: begin
                a = '0;
                b = opa;
                sub = 1'b1;
            end
            ALU_NONE, ALU_LOGIC: cin = 1'b0;
        endcase
        if (!is_word) begin
            a[WORD_W-1:BYTE_W] = '0;
            b[WORD_W-1:BYTE_W] = '0;
        end
        if (sub) begin
            sum = {1'b0, a} - {1'b0, b} - {{WORD_W{1'b0}}, cin};
        end else if (alu_op_t'(alu_op) == ALU_LOGIC) begin
            sum = {1'b0, a};
        end else begin
            sum = {1'b0, a} + {1'b0, b} + {{WORD_W{1'b0}}, cin};
        end
        msb = is_word ? WORD_W - 1 : BYTE_W - 1;
        hb = is_word ? HALF_BIT_WORD : HALF_BIT_BYTE;
        result = is_word ? sum[WORD_W-1:0] : {8'h00, sum[BYTE_W-1:0]};
        // carry or borrow out of bit 3 / bit 11 flips the next sum bit
        half_out = a[hb] ^ b[hb] ^ sum[hb];
        neg_out = result[msb];
        zero_out = (result == '0);
        carry_out = sum[msb+1];
        if (sub) begin
            ovf_out = (a[msb] != b[msb]) && (result[msb] != a[msb]);
        end else begin
            ovf_out = (a[msb] == b[msb]) && (result[msb] != a[msb]);
        end
        if (alu_op_t'(alu_op) == ALU_LOGIC) begin
            ovf_out = 1'b0;
            carry_out = carry_in;
        end
    end
endmodule // flag_calc

// File: dv/cpu_state_checker.sv
// concurrent checks on the ports of the cpu state block
`timescale 1ns/1ns
module cpu_state_checker
    import cpu_state_pkg::*;
(
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // vector and fetch
    input wire logic vec_rd_req,
    input wire logic vec_rd_ack,
    input wire logic [WORD_W-1:0] vec_rd_data,
    input wire logic [WORD_W-1:0] next_fetch_pointer,
    input wire logic [WORD_W-1:0] fetch_addr,
    input wire logic fetch_ready,
    input wire logic [WORD_W-1:0] data_addr_in,
    input wire logic data_is_word,
    input wire logic [WORD_W-1:0] data_addr_out,
    // flags
    input wire logic [2:0] flag_op,
    input wire logic [BYTE_W-1:0] flag_operand,
    input wire logic exception_start,
    input wire logic [BYTE_W-1:0] condition_flags,
    input wire logic irq_masked,
    input wire logic [2:0] alu_op,
    input wire logic alu_is_word,
    input wire logic [WORD_W-1:0] alu_opa,
    input wire logic [WORD_W-1:0] alu_opb,
    input wire logic [BYTE_W-1:0] flag_upd_mask,
    input wire logic carry_wr_en,
    input wire logic carry_wr_value,
    input wire logic bit_accum
);
    // ********
    // helpers
    // ********
    logic [4:0] low_sum;
    logic quiet;
    assign low_sum = {1'h0, alu_opa[3:0]} + {1'h0, alu_opb[3:0]};
    assign quiet = flag_op == FLG_NONE && alu_op == ALU_NONE
        && !carry_wr_en && !exception_start;
    sequence s_vec_taken;
        vec_rd_req && vec_rd_ack;
    endsequence
    sequence s_running;
        !vec_rd_req && fetch_ready;
    endsequence
    // ********
    // properties
    // ********
    property p_reset_state;
        @(posedge clk_sys) disable iff (rst)
        $fell(rst) |-> condition_flags == FLAGS_RESET && vec_rd_req;
    endproperty
    a_reset_state: assert property (p_reset_state)
        else $error("flags or vector request wrong after reset");
    property p_vector;
        @(posedge clk_sys) disable iff (rst)
        s_vec_taken |=> s_running ##0 next_fetch_pointer == $past(vec_rd_data);
    endproperty
    a_vector: assert property (p_vector)
        else $error("fetch pointer not loaded from vector");
    property p_fetch_align;
        @(posedge clk_sys) disable iff (rst)
        fetch_ready |-> fetch_addr == {next_fetch_pointer[15:1], 1'h0};
    endproperty
    a_fetch_align: assert property (p_fetch_align)
        else $error("fetch address low bit not cleared");
    property p_word_align;
        @(posedge clk_sys) disable iff (rst)
        data_addr_out == (data_addr_in & (data_is_word ? 16'hFFFE : 16'hFFFF));
    endproperty
    a_word_align: assert property (p_word_align)
        else $error("data address alignment wrong");
    property p_irq_view;
        @(posedge clk_sys) disable iff (rst)
        irq_masked == condition_flags[FLAG_I] && bit_accum == condition_flags[0];
    endproperty
    a_irq_view: assert property (p_irq_view)
        else $error("mask or accumulator view differs from flags");
    property p_exception;
        @(posedge clk_sys) disable iff (rst)
        exception_start && flag_op == FLG_NONE |=> condition_flags[FLAG_I];
    endproperty
    a_exception: assert property (p_exception)
        else $error("exception entry did not set mask");
    property p_flag_load;
        @(posedge clk_sys) disable iff (rst)
        flag_op == FLG_LOAD |=> condition_flags == $past(flag_operand);
    endproperty
    a_flag_load: assert property (p_flag_load)
        else $error("flag load wrong");
    property p_flag_or;
        @(posedge clk_sys) disable iff (rst)
        flag_op == FLG_OR |=>
            condition_flags == ($past(condition_flags) | $past(flag_operand));
    endproperty
    a_flag_or: assert property (p_flag_or)
        else $error("flag or wrong");
    property p_half_byte;
        @(posedge clk_sys) disable iff (rst)
        alu_op == ALU_ADD && !alu_is_word && flag_op == FLG_NONE
            && flag_upd_mask[FLAG_H] |=> condition_flags[FLAG_H] == $past(low_sum[4]);
    endproperty
    a_half_byte: assert property (p_half_byte)
        else $error("byte half carry wrong");
    property p_carry_wr;
        @(posedge clk_sys) disable iff (rst)
        carry_wr_en && flag_op == FLG_NONE && alu_op == ALU_NONE
            && !exception_start |=> condition_flags ==
            {$past(condition_flags[7:1]), $past(carry_wr_value)};
    endproperty
    a_carry_wr: assert property (p_carry_wr)
        else $error("carry write wrong");
    property p_hold;
        @(posedge clk_sys) disable iff (rst)
        quiet |=> $stable(condition_flags);
    endproperty
    a_hold: assert property (p_hold)
        else $error("flags changed without cause");
endmodule // cpu_state_checker

// File: dv/vector_source.sv
// model of the far side that answers the reset vector read
`timescale 1ns/1ns
module vector_source
    import cpu_state_pkg::*;
#(
    parameter int LATENCY = 3,
    parameter logic [WORD_W-1:0] VECTOR = 16'h1235
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // vector read
    input wire logic vec_rd_req,
    output logic vec_rd_ack,
    output logic [WORD_W-1:0] vec_rd_data
);
    logic [7:0] wait_r;
    // data toggles outside the ack so a stale word is never trusted
    always_ff @(posedge clk_sys) begin
        if (rst || !vec_rd_req || vec_rd_ack) begin
            wait_r <= 8'h00;
            vec_rd_ack <= 1'h0;
            vec_rd_data <= ~VECTOR;
        end else begin
            wait_r <= wait_r + 8'h01;
            vec_rd_ack <= wait_r == 8'(LATENCY);
            vec_rd_data <= (wait_r == 8'(LATENCY)) ? VECTOR : ~vec_rd_data;
        end
    end
endmodule // vector_source

// File: dv/testbench.sv
// self-checking bench for the cpu state block
`timescale 1ns/1ns
module testbench;
    import cpu_state_pkg::*;
    localparam logic [15:0] VEC = 16'h1235;
    logic clk_sys = 1'h0;
    logic rst = 1'h1;
    logic vec_rd_req, vec_rd_ack, fetch_ready, irq_masked, bit_accum;
    logic branch_taken, reg_wr_en, reg_wr_word, reg_rd_a_word, pc_load;
    logic pc_advance, data_is_word, exception_start, alu_is_word;
    logic carry_wr_en, carry_wr_value, da_is_sub;
    logic [3:0] reg_wr_sel, reg_rd_a_sel, branch_cond;
    logic [2:0] addr_rd_idx, flag_op, alu_op;
    logic [1:0] stack_op;
    logic [15:0] vec_rd_data, reg_wr_data, reg_rd_a_data, addr_rd_data;
    logic [15:0] stack_top_pointer, pc_load_value, next_fetch_pointer;
    logic [15:0] fetch_addr, data_addr_in, data_addr_out, alu_opa, alu_opb;
    logic [15:0] alu_result;
    logic [7:0] flag_operand, condition_flags, flag_upd_mask, da_in, da_out;
    int bad_count = 0;
    int n_compared = 0;
    always #5 clk_sys = ~clk_sys;
    cpu_state i_dut (.*);
    vector_source #(.LATENCY(3), .VECTOR(VEC)) i_vec (.clk_sys(clk_sys),
        .rst(rst), .vec_rd_req(vec_rd_req), .vec_rd_ack(vec_rd_ack),
        .vec_rd_data(vec_rd_data));
    // ********
    // tasks
    // ********
    task automatic step();
        @(negedge clk_sys);
    endtask
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            bad_count++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic results();
        $display("compared %0d mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    // each write holds one edge, then one idle edge
    task automatic wr_reg(input logic [3:0] s, input logic w,
                          input logic [15:0] d);
        reg_wr_sel = s;
        reg_wr_word = w;
        reg_wr_data = d;
        reg_wr_en = 1'h1;
        step();
        reg_wr_en = 1'h0;
        step();
    endtask
    task automatic rd_chk(input logic [3:0] s, input logic w,
                          input logic [15:0] exp);
        reg_rd_a_sel = s;
        reg_rd_a_word = w;
        step();
        check(reg_rd_a_data, exp);
    endtask
    task automatic fop(input logic [2:0] op, input logic [7:0] v);
        flag_op = op;
        flag_operand = v;
        step();
        flag_op = FLG_NONE;
        step();
    endtask
    task automatic alu_chk(input logic [2:0] op, input logic w,
        input logic [15:0] a, input logic [15:0] b, input logic [7:0] m,
        input logic [7:0] pre, input logic [15:0] res, input logic [7:0] fl);
        logic [15:0] got;
        fop(FLG_LOAD, pre);
        alu_op = op;
        alu_is_word = w;
        alu_opa = a;
        alu_opb = b;
        flag_upd_mask = m;
        #1 got = w ? alu_result : {8'h00, alu_result[7:0]};
        step();
        alu_op = ALU_NONE;
        step();
        check(got, res);
        check(condition_flags, fl);
    endtask
    // ********
    // sequence
    // ********
    initial begin
        {reg_wr_en, reg_wr_word, reg_rd_a_word, pc_load, pc_advance} = 5'h00;
        {data_is_word, exception_start, alu_is_word, carry_wr_en} = 4'h0;
        {carry_wr_value, da_is_sub, stack_op, addr_rd_idx} = 7'h00;
        {reg_wr_sel, reg_rd_a_sel, branch_cond, flag_op, alu_op} = 18'h00000;
        {reg_wr_data, pc_load_value, data_addr_in, alu_opa} = 64'h0;
        {alu_opb, flag_operand, flag_upd_mask, da_in} = 40'h0;
        repeat (4) step();
        rst = 1'h0;
        step();
        check(condition_flags, FLAGS_RESET);
        check(vec_rd_req, 1'h1);
        check(irq_masked, 1'h1);
        // a load while the vector is pending must be refused
        pc_load = 1'h1;
        pc_load_value = 16'h0F0E;
        step();
        pc_load = 1'h0;
        for (int i = 0; i < 20 && fetch_ready !== 1'h1; i++) step();
        if (fetch_ready !== 1'h1) begin
            bad_count++;
            results();
        end
        check(next_fetch_pointer, VEC);
        check(fetch_addr, VEC & 16'hFFFE);
        pc_advance = 1'h1;
        step();
        pc_advance = 1'h0;
        step();
        check(fetch_addr, 16'h1236);
        for (int i = 0; i < 8; i++) wr_reg(4'(i), 1'h1, 16'(16'h1111 * (i + 1)));
        for (int i = 0; i < 8; i++) begin
            addr_rd_idx = 3'(i);
            step();
            check(addr_rd_data, 16'(16'h1111 * (i + 1)));
        end
        wr_reg(4'h2, 1'h0, 16'h00C3);
        wr_reg(4'hD, 1'h0, 16'h005A);
        rd_chk(4'h2, 1'h1, 16'hC333);
        rd_chk(4'h2, 1'h0, 16'h00C3);
        rd_chk(4'hA, 1'h0, 16'h0033);
        rd_chk(4'h5, 1'h1, 16'h665A);
        wr_reg(4'h7, 1'h1, 16'h0FF0);
        check(stack_top_pointer, 16'h0FF0);
        stack_op = STK_PUSH;
        step();
        stack_op = STK_NONE;
        step();
        check(stack_top_pointer, 16'h0FEE);
        stack_op = STK_POP;
        step();
        stack_op = STK_NONE;
        addr_rd_idx = STACK_REG_IDX;
        step();
        check(stack_top_pointer, 16'h0FF0);
        check(addr_rd_data, 16'h0FF0);
        fop(FLG_LOAD, 8'h50);
        check(condition_flags, 8'h50);
        check(irq_masked, 1'h0);
        fop(FLG_OR, 8'h8A);
        check(condition_flags, 8'hDA);
        fop(FLG_AND, 8'hF0);
        check(condition_flags, 8'hD0);
        fop(FLG_XOR, 8'h41);
        check(condition_flags, 8'h91);
        fop(FLG_LOAD, 8'h00);
        exception_start = 1'h1;
        step();
        exception_start = 1'h0;
        step();
        check(condition_flags, 8'h80);
        alu_chk(ALU_ADD, 0, 16'h0F, 16'h01, 8'h2F, 8'h00, 16'h10, 8'h20);
        alu_chk(ALU_ADD, 0, 16'h7F, 16'h01, 8'h2F, 8'h00, 16'h80, 8'h2A);
        alu_chk(ALU_ADD, 0, 16'hFF, 16'h01, 8'h2F, 8'h00, 16'h00, 8'h25);
        alu_chk(ALU_ADDC, 0, 16'h0E, 16'h01, 8'h2F, 8'h01, 16'h10, 8'h20);
        alu_chk(ALU_SUB, 0, 16'h10, 16'h01, 8'h2F, 8'h00, 16'h0F, 8'h20);
        alu_chk(ALU_SUBC, 0, 16'h10, 16'h00, 8'h2F, 8'h01, 16'h0F, 8'h20);
        alu_chk(ALU_CMP, 0, 16'h05, 16'h05, 8'h2F, 8'h00, 16'h00, 8'h04);
        alu_chk(ALU_NEG, 0, 16'h01, 16'h01, 8'h2F, 8'h00, 16'hFF, 8'h29);
        alu_chk(ALU_ADD, 1, 16'h0FFF, 16'h1, 8'h2F, 8'h0, 16'h1000, 8'h20);
        alu_chk(ALU_SUB, 1, 16'h1000, 16'h1, 8'h2F, 8'h0, 16'h0FFF, 8'h20);
        alu_chk(ALU_ADD, 0, 16'hFF, 16'h01, 8'h01, 8'h50, 16'h00, 8'h51);
        fop(FLG_LOAD, 8'h50);
        carry_wr_en = 1'h1;
        carry_wr_value = 1'h1;
        step();
        carry_wr_en = 1'h0;
        step();
        check(condition_flags, 8'h51);
        check(bit_accum, 1'h1);
        branch_cond = 4'h4;
        #1 check(branch_taken, 1'h0);
        branch_cond = 4'h6;
        #1 check(branch_taken, 1'h1);
        fop(FLG_LOAD, 8'h20);
        da_in = 8'h12;
        step();
        check(da_out, 8'h18);
        da_is_sub = 1'h1;
        da_in = 8'h0F;
        step();
        check(da_out, 8'h09);
        for (int i = 0; i < 2; i++) begin
            data_addr_in = i ? 16'hFFFF : 16'h1235;
            data_is_word = 1'h1;
            step();
            check(data_addr_out, data_addr_in & 16'hFFFE);
            data_is_word = 1'h0;
            step();
            check(data_addr_out, data_addr_in);
        end
        results();
    end
endmodule // testbench
bind cpu_state cpu_state_checker i_chk (.*);
